// ===== verilog/fbm_host.sv
// How it works
// - read: select and output gate low, write strobe high; device drives byte.
// - write: strobe and select low, output gate high; host drives data.
// - host waits full chip-select access time before sampling read data.
// - raised-voltage autoselect: A9 high voltage, A6 low, A1/A0 choose code.
// - protection check drives sector bits; bit 0 set means protected.
module fbm_host #(
  parameter int CE_CYC = fbm_pkg::CE_CYC,
  parameter int OE_CYC = fbm_pkg::OE_CYC,
  parameter int WP_CYC = fbm_pkg::WP_CYC,
  parameter int HOLD_CYC = fbm_pkg::HOLD_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire fbm_pkg::fbm_op_t req_op,
  input wire logic [fbm_pkg::ADDR_W-1:0] req_addr,
  input wire logic [fbm_pkg::DATA_W-1:0] req_wdata,
  input wire logic [1:0] req_id_sel,
  input wire logic [fbm_pkg::SECT_W-1:0] req_sector,
  // answer
  output logic rsp_valid,
  output logic [fbm_pkg::DATA_W-1:0] rsp_rdata,
  output logic rsp_protected,
  // device pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic hv_en,
  output logic [fbm_pkg::ADDR_W-1:0] addr,
  output logic [fbm_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [fbm_pkg::DATA_W-1:0] dq_in
);
  // ==========================================================
  // state
  typedef enum logic [2:0] {
    FBM_IDLE,
    FBM_SETUP,
    FBM_RD_WAIT,
    FBM_RD_SAMPLE,
    FBM_WR_PULSE,
    FBM_HOLD
  } fbm_state_t;

  fbm_pins_if pins ();
  fbm_state_t state_q, state_d;
  logic [fbm_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic is_write_q, is_id_q;
  logic is_prot_q;
  logic prot_q;
  logic [fbm_pkg::ADDR_W-1:0] addr_q;
  logic [fbm_pkg::DATA_W-1:0] wdata_q;
  logic [fbm_pkg::DATA_W-1:0] rdata_q;
  logic rsp_valid_q;

  function automatic logic [fbm_pkg::CNT_W-1:0] fbm_cnt(input int n);
    fbm_cnt = fbm_pkg::CNT_W'(n);
  endfunction : fbm_cnt

  // ==========================================================
  // state decode
  // named wires for the idle, sample and hold state tests keep strobes and sequencer in step
  wire logic st_idle = (state_q == FBM_IDLE);
  wire logic st_sample = (state_q == FBM_RD_SAMPLE);
  wire logic st_hold = (state_q == FBM_HOLD);

  // ==========================================================
  // address shaping
  wire logic take = req_valid && req_ready;
  wire logic is_id_req = (req_op == fbm_pkg::FBM_OP_ID);
  wire logic is_prot_req = is_id_req && (req_id_sel == fbm_pkg::AS_SEL_PROT);
  wire logic prot_bit = ((pins.data_in_sync & fbm_pkg::PROT_MASK) != '0);
  // high-voltage autoselect: A9 raised, A6 low, A1/A0 pick the code, sector on top bits
  wire logic [fbm_pkg::ADDR_W-1:0] id_addr =
    (fbm_pkg::ADDR_W'(req_sector) << fbm_pkg::SECT_LSB)
    | (fbm_pkg::ADDR_W'(req_id_sel[1]) << fbm_pkg::AS_A1_BIT)
    | (fbm_pkg::ADDR_W'(req_id_sel[0]) << fbm_pkg::AS_A0_BIT);
  wire logic [fbm_pkg::ADDR_W-1:0] next_addr = is_id_req ? id_addr : req_addr;

  // ==========================================================
  // sequencer
  // the full chip-select access time is counted even for back-to-back reads,
  // since chip select is released between cycles
  wire logic cnt_done = (cnt_q == '0);
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_q - fbm_cnt(1);
    unique case (state_q)
      FBM_IDLE: begin
        if (take) begin
          state_d = FBM_SETUP;
          cnt_d = '0;
        end
      end
      FBM_SETUP: begin
        if (is_write_q) begin
          state_d = FBM_WR_PULSE;
          cnt_d = fbm_cnt(WP_CYC - 1);
        end else begin
          state_d = FBM_RD_WAIT;
          // pin register plus two sync stages add latency on top of access time
          cnt_d = fbm_cnt((CE_CYC > OE_CYC ? CE_CYC : OE_CYC) + 2);
        end
      end
      FBM_RD_WAIT: begin
        if (cnt_done) begin
          state_d = FBM_RD_SAMPLE;
        end
      end
      FBM_RD_SAMPLE: begin
        state_d = FBM_HOLD;
        cnt_d = fbm_cnt(HOLD_CYC);
      end
      FBM_WR_PULSE: begin
        if (cnt_done) begin
          state_d = FBM_HOLD;
          cnt_d = fbm_cnt(HOLD_CYC);
        end
      end
      FBM_HOLD: begin
        if (cnt_done) begin
          state_d = FBM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= FBM_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      is_write_q <= 1'b0;
      is_id_q <= 1'b0;
      is_prot_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (take) begin
      is_write_q <= (req_op == fbm_pkg::FBM_OP_WRITE);
      is_id_q <= is_id_req;
      is_prot_q <= is_prot_req;
      addr_q <= next_addr;
      wdata_q <= req_wdata;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rsp_valid_q <= 1'b0;
      prot_q <= 1'b0;
    end else begin
      rsp_valid_q <= st_sample;
      // only the protection selection sets the flag: an id code may have bit 0 set
      prot_q <= st_sample && is_prot_q && prot_bit;
      if (st_sample) begin
        rdata_q <= pins.data_in_sync;
      end
    end
  end

  // ==========================================================
  // strobe decode
  wire logic in_cycle = !st_idle;
  wire logic rd_phase = (state_q == FBM_RD_WAIT) || st_sample;
  wire logic wr_phase = (state_q == FBM_WR_PULSE);
  // address is set up in SETUP with strobe high, so the device latches it
  // on the write strobe fall; data stays put through HOLD past the rise
  assign pins.chip_select_low = !(in_cycle && (!st_hold || is_write_q));
  assign pins.output_gate_low = !rd_phase;
  assign pins.write_strobe_low = !wr_phase;
  assign pins.high_voltage_en = in_cycle && is_id_q;
  assign pins.address_pins = addr_q;
  assign pins.data_out = wdata_q;
  // host drives data only while output gate is high, so no fight with
  assign pins.data_oe_n = !(is_write_q && in_cycle && !rd_phase);

  fbm_pin_drv u_drv (
    .clk(clk),
    .sys_rst(sys_rst),
    .pins(pins),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n),
    .hv_en(hv_en),
    .addr(addr),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .dq_in(dq_in)
  );

  // ==========================================================
  // answer
  assign req_ready = st_idle;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign rsp_protected = prot_q;
endmodule : fbm_host

// ===== verilog/fbm_pkg.sv
package fbm_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int SECT_W = 3;
  localparam int SECT_LSB = 14;
  localparam int SECT_COUNT = 8;
  // ==========================================================
  // raised-voltage autoselect address bits
  localparam int HV_BIT = 9;
  localparam int AS_SEL_BIT = 6;
  localparam int AS_A1_BIT = 1;
  localparam int AS_A0_BIT = 0;
  localparam logic [1:0] AS_SEL_MFR = 2'h0;
  localparam logic [1:0] AS_SEL_DEV = 2'h1;
  localparam logic [1:0] AS_SEL_PROT = 2'h2;
  localparam logic [7:0] PROT_MASK = 8'h01;
  // ==========================================================
  // timing
  localparam int CLK_NS = 100;
  localparam int T_CE_NS = 120;
  localparam int T_OE_NS = 50;
  localparam int T_WP_NS = 100;
  localparam int T_HOLD_NS = 100;
  localparam int CE_CYC = (T_CE_NS + CLK_NS - 1) / CLK_NS;
  localparam int OE_CYC = (T_OE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  // ==========================================================
  // host requests
  typedef enum logic [1:0] {
    FBM_OP_READ,
    FBM_OP_WRITE,
    FBM_OP_ID
  } fbm_op_t;
endpackage : fbm_pkg

// ===== verilog/fbm_pins_if.sv
interface fbm_pins_if;
  logic chip_select_low;
  logic output_gate_low;
  logic write_strobe_low;
  logic high_voltage_en;
  logic [fbm_pkg::ADDR_W-1:0] address_pins;
  logic [fbm_pkg::DATA_W-1:0] data_out;
  logic data_oe_n;
  logic [fbm_pkg::DATA_W-1:0] data_in_sync;
  modport ctl (
    output chip_select_low, output_gate_low, write_strobe_low, high_voltage_en,
    output address_pins, data_out, data_oe_n,
    input data_in_sync
  );
  modport drv (
    input chip_select_low, output_gate_low, write_strobe_low, high_voltage_en,
    input address_pins, data_out, data_oe_n,
    output data_in_sync
  );
endinterface : fbm_pins_if

// ===== verilog/fbm_pin_drv.sv
module fbm_pin_drv (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // internal side
  fbm_pins_if.drv pins,
  // device pins
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic hv_en,
  output logic [fbm_pkg::ADDR_W-1:0] addr,
  output logic [fbm_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [fbm_pkg::DATA_W-1:0] dq_in
);
  // ==========================================================
  // pin registers: glitch-free strobes, no combinational paths out
  logic [fbm_pkg::DATA_W-1:0] meta_q;
  logic [fbm_pkg::DATA_W-1:0] sync_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      hv_en <= 1'b0;
      addr <= '0;
      dq_out <= '0;
      dq_oe_n <= 1'b1;
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      ce_n <= pins.chip_select_low;
      oe_n <= pins.output_gate_low;
      we_n <= pins.write_strobe_low;
      hv_en <= pins.high_voltage_en;
      addr <= pins.address_pins;
      dq_out <= pins.data_out;
      dq_oe_n <= pins.data_oe_n;
      meta_q <= dq_in;
      sync_q <= meta_q;
    end
  end
  assign pins.data_in_sync = sync_q;
endmodule : fbm_pin_drv

// ===== sim/fbm_host_chk.sv
module fbm_host_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // answer
  input wire logic rsp_valid,
  input wire logic [fbm_pkg::DATA_W-1:0] rsp_rdata,
  input wire logic rsp_protected,
  // device pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv_en,
  input wire logic dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // pin relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rd_combo; !oe_n |-> !ce_n && we_n && dq_oe_n; endproperty
  a_rd_combo: assert property (p_rd_combo)
    else $error("output gate low outside a read");
  property p_wr_combo; !we_n |-> !ce_n && oe_n && !dq_oe_n; endproperty
  a_wr_combo: assert property (p_wr_combo)
    else $error("write strobe low outside a write");
  property p_ce_lead; $fell(we_n) |-> !$past(ce_n); endproperty
  a_ce_lead: assert property (p_ce_lead)
    else $error("select not low before write strobe");
  property p_ce_trail; $rose(we_n) |-> !ce_n; endproperty
  a_ce_trail: assert property (p_ce_trail)
    else $error("select released before write strobe");
  // sampling too early would read a byte the device has not settled yet
  property p_access; $fell(oe_n) |-> !ce_n throughout (##[4:6] rsp_valid); endproperty
  a_access: assert property (p_access)
    else $error("read answer outside access window");
  property p_rsp_hold; $rose(oe_n) |-> $past(rsp_valid); endproperty
  a_rsp_hold: assert property (p_rsp_hold)
    else $error("output gate released before data taken");
  property p_prot; rsp_protected |-> rsp_valid && rsp_rdata[0]; endproperty
  a_prot: assert property (p_prot)
    else $error("protected flag without bit zero");
  property p_hv_read; hv_en |-> we_n; endproperty
  a_hv_read: assert property (p_hv_read)
    else $error("raised voltage during a write");
endmodule : fbm_host_chk

bind fbm_host fbm_host_chk i_chk (.clk, .sys_rst, .rsp_valid, .rsp_rdata, .rsp_protected,
  .ce_n, .oe_n, .we_n, .hv_en, .dq_oe_n);

// ===== sim/fbm_flash_model.sv
module fbm_flash_model #(
  parameter logic [7:0] MFR_CODE = 8'h5A, // arbitrary
  parameter logic [7:0] DEV_CODE = 8'hC3, // arbitrary
  parameter logic [7:0] PROT_MAP = 8'hA6,
  parameter logic [7:0] CMD_ID = 8'h3C, // arbitrary
  parameter logic [7:0] CMD_OP = 8'h6B, // arbitrary
  parameter logic [4:0] STAT_TAG = 5'h15, // arbitrary
  parameter int BUSY_READS = 2
) (
  // strobes and address
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hv_en,
  input wire logic [16:0] addr,
  // data
  input wire logic [7:0] dq_out,
  output logic [7:0] dq_in,
  // latched write cycle
  output logic [16:0] wr_addr,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive;
  logic [7:0] rd_val;
  logic [7:0] last_q = 8'h00;
  logic as_mode = 1'b0;
  logic [2:0] op_sect = '0;
  int rd_cnt = 0;
  int busy_end = 0;
  // an operation lasts a fixed number of reads, whatever ce_n does meanwhile
  wire logic busy = (rd_cnt < busy_end);
  wire logic id_mode = (hv_en && !addr[6]) || as_mode;
  always @(posedge oe_n) rd_cnt <= rd_cnt + 1;
  assign drive = !ce_n && !oe_n && we_n;
  always_comb begin
    if (busy) rd_val = {STAT_TAG, op_sect};
    else if (!id_mode) rd_val = addr[7:0] ^ {addr[16:14], addr[13:9]};
    else if (addr[1:0] == 2'h0) rd_val = MFR_CODE;
    else if (addr[1:0] == 2'h1) rd_val = DEV_CODE;
    else rd_val = {7'h0, PROT_MAP[addr[16:14]]};
  end
  always @(rd_val or drive) if (drive) last_q = rd_val;
  // a released bus shows the inverse, so a late sample cannot pass by luck
  assign dq_in = drive ? rd_val : ~last_q;
  always @(negedge we_n or negedge ce_n) if (!we_n && !ce_n && oe_n) wr_addr <= addr;
  always @(posedge we_n or posedge ce_n) begin
    if (we_n != ce_n && oe_n) begin
      wr_data <= dq_out;
      as_mode <= (dq_out == CMD_ID);
      if (dq_out == CMD_OP) begin
        busy_end <= rd_cnt + BUSY_READS;
        op_sect <= wr_addr[16:14];
      end
    end
  end
endmodule : fbm_flash_model

// ===== sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  localparam logic [7:0] PMAP = 8'hA6;
  localparam logic [7:0] CMD_ID = 8'h3C;
  localparam logic [7:0] CMD_OP = 8'h6B;
  localparam logic [4:0] STAT_TAG = 5'h15;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  fbm_pkg::fbm_op_t req_op = fbm_pkg::FBM_OP_READ;
  logic [16:0] req_addr = '0;
  logic [7:0] req_wdata = '0;
  logic [1:0] req_id_sel = '0;
  logic [2:0] req_sector = '0;
  logic req_ready, rsp_valid, rsp_protected, ce_n, oe_n, we_n, hv_en, dq_oe_n, pr;
  logic [16:0] addr, wr_addr;
  logic [7:0] rsp_rdata, dq_out, dq_in, wr_data, rd;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  fbm_host i_dut (.clk, .sys_rst, .req_valid, .req_ready, .req_op, .req_addr, .req_wdata,
    .req_id_sel, .req_sector, .rsp_valid, .rsp_rdata, .rsp_protected, .ce_n, .oe_n, .we_n,
    .hv_en, .addr, .dq_out, .dq_oe_n, .dq_in);
  fbm_flash_model #(.PROT_MAP(PMAP), .CMD_ID(CMD_ID), .CMD_OP(CMD_OP), .STAT_TAG(STAT_TAG))
    i_mdl (.ce_n, .oe_n, .we_n, .hv_en, .addr, .dq_out, .dq_in, .wr_addr, .wr_data);
  // ==========================================================
  // helpers
  function automatic logic [7:0] arr(input logic [16:0] a);
    return a[7:0] ^ {a[16:14], a[13:9]};
  endfunction : arr
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // one request; inputs move and req_ready is read 10 ns after the edge, the answer is read 1 ns after it
  task automatic xfer(input fbm_pkg::fbm_op_t op, input logic [16:0] a,
    input logic [7:0] wd, input logic [1:0] sel, input logic [2:0] sec);
    req_op = op;
    req_addr = a;
    req_wdata = wd;
    req_id_sel = sel;
    req_sector = sec;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(posedge clk) #10;
    @(posedge clk) #10;
    req_valid = 1'b0;
    if (op != fbm_pkg::FBM_OP_WRITE) begin
      while (rsp_valid !== 1'b1) @(posedge clk) #1;
      rd = rsp_rdata;
      pr = rsp_protected;
      #9;
    end
    while (req_ready !== 1'b1) @(posedge clk) #10;
  endtask : xfer
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check({ce_n, oe_n, we_n, dq_oe_n, hv_en}, 17'h0_001E);
    xfer(fbm_pkg::FBM_OP_READ, 17'h0_0123, 8'h00, 2'h0, 3'h0);
    check(rd, arr(17'h0_0123));
  endtask : t_reset
  task automatic t_sectors();
    for (int s = 0; s < 8; s++) begin
      xfer(fbm_pkg::FBM_OP_READ, {s[2:0], 14'h3FFF}, 8'h00, 2'h0, 3'h0);
      check(rd, arr({s[2:0], 14'h3FFF}));
      xfer(fbm_pkg::FBM_OP_READ, {s[2:0], 14'h0000}, 8'h00, 2'h0, 3'h0);
      check(rd, arr({s[2:0], 14'h0000}));
    end
  endtask : t_sectors
  task automatic t_write();
    xfer(fbm_pkg::FBM_OP_WRITE, 17'h1_C555, 8'hA5, 2'h0, 3'h0);
    check(wr_addr, 17'h1_C555);
    check(wr_data, 8'hA5);
    xfer(fbm_pkg::FBM_OP_READ, 17'h1_C555, 8'h00, 2'h0, 3'h0);
    check(rd, arr(17'h1_C555));
  endtask : t_write
  task automatic t_ident();
    xfer(fbm_pkg::FBM_OP_ID, 17'h0_0000, 8'h00, fbm_pkg::AS_SEL_MFR, 3'h0);
    check({pr, rd}, {1'b0, 8'h5A});
    xfer(fbm_pkg::FBM_OP_ID, 17'h0_0000, 8'h00, fbm_pkg::AS_SEL_DEV, 3'h0);
    check({pr, rd}, {1'b0, 8'hC3});
    for (int s = 0; s < 8; s++) begin
      xfer(fbm_pkg::FBM_OP_ID, 17'h0_0000, 8'h00, fbm_pkg::AS_SEL_PROT, s[2:0]);
      check({pr, rd}, {PMAP[s], 7'h00, PMAP[s]});
    end
  endtask : t_ident
  task automatic t_cmd();
    xfer(fbm_pkg::FBM_OP_WRITE, 17'h0_0000, CMD_ID, 2'h0, 3'h0);
    xfer(fbm_pkg::FBM_OP_READ, 17'h0_0000, 8'h00, 2'h0, 3'h0);
    check(rd, 8'h5A);
    xfer(fbm_pkg::FBM_OP_READ, 17'h1_4002, 8'h00, 2'h0, 3'h0);
    check(rd, {7'h00, PMAP[5]});
    xfer(fbm_pkg::FBM_OP_WRITE, 17'h0_0000, 8'h00, 2'h0, 3'h0);
    xfer(fbm_pkg::FBM_OP_READ, 17'h0_0002, 8'h00, 2'h0, 3'h0);
    check(rd, arr(17'h0_0002));
    xfer(fbm_pkg::FBM_OP_WRITE, 17'h1_9234, CMD_OP, 2'h0, 3'h0);
    xfer(fbm_pkg::FBM_OP_READ, 17'h0_0040, 8'h00, 2'h0, 3'h0);
    check(rd, {STAT_TAG, 3'h6});
    xfer(fbm_pkg::FBM_OP_READ, 17'h0_0041, 8'h00, 2'h0, 3'h0);
    check(rd, {STAT_TAG, 3'h6});
    xfer(fbm_pkg::FBM_OP_READ, 17'h0_0042, 8'h00, 2'h0, 3'h0);
    check(rd, arr(17'h0_0042));
  endtask : t_cmd
  // ==========================================================
  // run
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    #10;
    sys_rst = 1'b0;
    t_reset();
    t_sectors();
    t_write();
    t_ident();
    t_cmd();
    report_and_stop();
  end
endmodule : tb_top
